// ### rtl/dgr_pkg.sv
/*
  Constants, register map and field layout of the digitizer group register bank.
  Assumes a single 200 MHz clock and a synchronous active-high reset.
*/
// Behaviour
// - Revision reads date, major, minor fields
// - Occupancy read-only, eleven bits, 0 to 1024
// - Offset write loads channel or all eight
// - Offset DACs reset to 0x8f00
// - Offset read uses readout select index
// - Readout select holds four-bit channel index
// - Temperature is eight-bit read-only value
// - Calibration enable bit zero grants access
// - Calibration data byte serialized or fetched
// - Threshold shared by both group addresses
// - Trigger offset shared, defaults to 0x1000
// - Config bits 31:28 select monitor output
// - Config bit 12 enables local trigger
// - Config bit 11 adds trigger to readout
// - Config bit 6 selects trigger polarity
// - Config bit 3 selects sawtooth test data
// - Base address write replaces whole config
// - Set alias sets written one bits
// - Clear alias clears written one bits
// - Two groups selected by address digit
// - Status bit 2 shows serial busy
package dgr_pkg;

  // ----------------------------------------
  // Register offsets: group page registers, group stride mask and board-wide config registers
  // ----------------------------------------
  localparam logic [15:0] OFS_STATUS = 16'h1088;
  localparam logic [15:0] OFS_FW_REV = 16'h108c;
  localparam logic [15:0] OFS_OCCUPANCY = 16'h1094;
  localparam logic [15:0] OFS_OFFSET_DAC = 16'h1098;
  localparam logic [15:0] OFS_CONV_RSVD = 16'h109c;
  localparam logic [15:0] OFS_TEMP = 16'h10a0;
  localparam logic [15:0] OFS_DAC_SEL = 16'h10a4;
  localparam logic [15:0] OFS_TRIGMASK_RSVD = 16'h10a8;
  localparam logic [15:0] OFS_CAL_EN = 16'h10cc;
  localparam logic [15:0] OFS_CAL_DATA = 16'h10d0;
  localparam logic [15:0] OFS_FT_THRESH = 16'h10d4;
  localparam logic [15:0] OFS_FT_OFFSET = 16'h10dc;
  localparam logic [15:0] GROUP_STRIDE_MASK = 16'h0100;
  localparam logic [15:0] OFS_CFG = 16'h8000;
  localparam logic [15:0] OFS_CFG_SET = 16'h8004;
  localparam logic [15:0] OFS_CFG_CLR = 16'h8008;
  localparam logic [15:0] OFS_BUF_RSVD = 16'h800c;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int NUM_GROUPS = 2;
  localparam int CH_PER_GROUP = 8;
  localparam logic [3:0] CH_ALL = 4'hf;
  localparam int IDX_LSB = 16;
  localparam int STATUS_BUSY_BIT = 2;
  localparam int CFG_MON_LSB = 28;
  localparam int CFG_FT_TRIG_BIT = 12;
  localparam int CFG_FT_READ_BIT = 11;
  localparam int CFG_FT_POL_BIT = 6;
  localparam int CFG_TEST_BIT = 3;
  localparam logic [15:0] OFFSET_DAC_RST = 16'h8f00;
  localparam logic [15:0] FT_OFFSET_RST = 16'h1000;
  localparam logic [15:0] FT_THRESH_RST = 16'h0000;
  localparam logic [31:0] CFG_RST = 32'h0000_0110;
  localparam logic [10:0] OCC_MAX = 11'h400;

  // Serial word: 2-bit target, 1-bit group, 4-bit index, 16-bit data.
  localparam int SER_BITS = 23;
  localparam logic [4:0] SER_CNT_LAST = 5'h16;
  localparam logic [1:0] TGT_OFFSET = 2'h0;
  localparam logic [1:0] TGT_FT_THRESH = 2'h1;
  localparam logic [1:0] TGT_FT_OFFSET = 2'h2;
  localparam logic [1:0] TGT_CAL = 2'h3;

  // Monitor selections.
  typedef enum logic [3:0] {
    MON_NONE = 4'h0,
    MON_ALL_FT = 4'h1,
    MON_ACC_FT = 4'h2,
    MON_BUSY = 4'h3
  } dgr_mon_e;

endpackage : dgr_pkg

// ### rtl/dgr_bank.sv
/*
  Group register bank: revision, occupancy, offset DACs, temperature, calibration
  access, shared fast trigger DACs and the board-wide group configuration register.
  Assumes one-cycle write and read strobes with a 16-bit byte address and 32-bit data;
  read data is registered and valid the cycle after the read strobe.
*/
`timescale 1ns/1ps
module dgr_bank (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  output logic reg_rvalid_out,
  input wire logic [31:0] fw_revision_in,
  input wire logic [10:0] occupancy0_in,
  input wire logic [10:0] occupancy1_in,
  input wire logic [7:0] temp0_in,
  input wire logic [7:0] temp1_in,
  input wire logic [7:0] cal_rdata_in,
  input wire logic [3:0] ext_status_in,
  output logic ser_clk_out,
  output logic ser_data_out,
  output logic ser_frame_out,
  output logic [1:0] cal_enable_out,
  output logic [15:0] ft_threshold_out,
  output logic [15:0] ft_offset_out,
  output logic [3:0] monitor_sel_out,
  output logic ft_trigger_en_out,
  output logic ft_readout_en_out,
  output logic ft_falling_edge_out,
  output logic test_sawtooth_out,
  output logic [15:0] offset_dac_out [0:15]
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------

  // Group page offset: the group digit sits in address bit 8.
  function automatic logic is_grp_reg(input logic [15:0] a, input logic [15:0] ofs);
    is_grp_reg = ((a & ~dgr_pkg::GROUP_STRIDE_MASK) == ofs);
  endfunction : is_grp_reg

  logic grp;
  logic busy;
  logic [31:0] cfg;
  logic [3:0] dac_sel [0:1];
  logic [15:0] offset_dac [0:15];
  localparam int SER_W = dgr_pkg::SER_BITS;
  logic [SER_W-1:0] ser_shift;
  logic [4:0] ser_cnt;
  logic ser_start;
  logic [22:0] next_word;

  assign grp = reg_addr_in[8];

  // ----------------------------------------
  // Serial word launch
  // ----------------------------------------
  // A write while busy is dropped on purpose; software owns the wait.
  always_comb
  begin
    ser_start = 1'b0;
    next_word = '0;
    if (reg_wr_in && !busy)
    begin
      if (is_grp_reg(reg_addr_in, dgr_pkg::OFS_OFFSET_DAC))
      begin
        ser_start = 1'b1;
        next_word = {dgr_pkg::TGT_OFFSET, grp, reg_wdata_in[19:16], reg_wdata_in[15:0]};
      end
      else if (is_grp_reg(reg_addr_in, dgr_pkg::OFS_FT_THRESH))
      begin
        ser_start = 1'b1;
        next_word = {dgr_pkg::TGT_FT_THRESH, grp, 4'h0, reg_wdata_in[15:0]};
      end
      else if (is_grp_reg(reg_addr_in, dgr_pkg::OFS_FT_OFFSET))
      begin
        ser_start = 1'b1;
        next_word = {dgr_pkg::TGT_FT_OFFSET, grp, 4'h0, reg_wdata_in[15:0]};
      end
      else if (is_grp_reg(reg_addr_in, dgr_pkg::OFS_CAL_DATA))
      begin
        ser_start = 1'b1;
        next_word = {dgr_pkg::TGT_CAL, grp, 4'h0, 8'h00, reg_wdata_in[7:0]};
      end
    end
  end

  // ----------------------------------------
  // Serial shifter and busy flag
  // ----------------------------------------
  // One bit per two clocks; MSB first with frame high for the whole word.
  logic ser_phase;
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      busy <= 1'b0;
      ser_shift <= '0;
      ser_cnt <= 5'h00;
      ser_phase <= 1'b0;
    end
    else if (ser_start)
    begin
      busy <= 1'b1;
      ser_shift <= next_word;
      ser_cnt <= 5'h00;
      ser_phase <= 1'b0;
    end
    else if (busy)
    begin
      ser_phase <= ~ser_phase;
      if (ser_phase)
      begin
        ser_shift <= {ser_shift[SER_W-2:0], 1'b0};
        ser_cnt <= ser_cnt + 5'h01;
        if (ser_cnt == dgr_pkg::SER_CNT_LAST)
        begin
          busy <= 1'b0;
        end
      end
    end
  end

  assign ser_clk_out = busy & ser_phase;
  assign ser_data_out = busy & ser_shift[SER_W-1];
  assign ser_frame_out = busy;

  // ----------------------------------------
  // Offset DAC shadow values
  // ----------------------------------------
  // Shadows update on acceptance so reads follow the last accepted value.
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      for (int i = 0; i < 16; i++)
      begin
        offset_dac[i] <= dgr_pkg::OFFSET_DAC_RST;
      end
    end
    else if (ser_start && is_grp_reg(reg_addr_in, dgr_pkg::OFS_OFFSET_DAC))
    begin
      for (int i = 0; i < 8; i++)
      begin
        if (reg_wdata_in[19:16] == dgr_pkg::CH_ALL || reg_wdata_in[19:16] == 4'(i))
        begin
          offset_dac[{grp, 3'(i)}] <= reg_wdata_in[15:0];
        end
      end
    end
  end

  assign offset_dac_out = offset_dac;

  // ----------------------------------------
  // Simple writable registers
  // ----------------------------------------
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      dac_sel[0] <= 4'h0;
      dac_sel[1] <= 4'h0;
      cal_enable_out <= 2'h0;
      ft_threshold_out <= dgr_pkg::FT_THRESH_RST;
      ft_offset_out <= dgr_pkg::FT_OFFSET_RST;
    end
    else if (reg_wr_in)
    begin
      if (is_grp_reg(reg_addr_in, dgr_pkg::OFS_DAC_SEL))
      begin
        dac_sel[grp] <= reg_wdata_in[3:0];
      end
      if (is_grp_reg(reg_addr_in, dgr_pkg::OFS_CAL_EN) && !busy)
      begin
        cal_enable_out[grp] <= reg_wdata_in[0];
      end
      if (ser_start && is_grp_reg(reg_addr_in, dgr_pkg::OFS_FT_THRESH))
      begin
        ft_threshold_out <= reg_wdata_in[15:0];
      end
      if (ser_start && is_grp_reg(reg_addr_in, dgr_pkg::OFS_FT_OFFSET))
      begin
        ft_offset_out <= reg_wdata_in[15:0];
      end
    end
  end

  // ----------------------------------------
  // Group configuration with set and clear aliases
  // ----------------------------------------
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      cfg <= dgr_pkg::CFG_RST;
    end
    else if (reg_wr_in)
    begin
      case (reg_addr_in)
        dgr_pkg::OFS_CFG: cfg <= reg_wdata_in;
        dgr_pkg::OFS_CFG_SET: cfg <= cfg | reg_wdata_in;
        dgr_pkg::OFS_CFG_CLR: cfg <= cfg & ~reg_wdata_in;
        default: cfg <= cfg;
      endcase
    end
  end

  // Software keeps the mandatory bits; the bank stores them as written.
  assign monitor_sel_out = cfg[dgr_pkg::CFG_MON_LSB +: 4];
  assign ft_trigger_en_out = cfg[dgr_pkg::CFG_FT_TRIG_BIT];
  assign ft_readout_en_out = cfg[dgr_pkg::CFG_FT_READ_BIT];
  assign ft_falling_edge_out = cfg[dgr_pkg::CFG_FT_POL_BIT];
  assign test_sawtooth_out = cfg[dgr_pkg::CFG_TEST_BIT];

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [31:0] next_rdata;
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (is_grp_reg(reg_addr_in, dgr_pkg::OFS_STATUS))
      next_rdata = {28'h0, ext_status_in[3], busy, ext_status_in[1:0]};
    else if (is_grp_reg(reg_addr_in, dgr_pkg::OFS_FW_REV))
      next_rdata = fw_revision_in;
    else if (is_grp_reg(reg_addr_in, dgr_pkg::OFS_OCCUPANCY))
      next_rdata = {21'h0, grp ? occupancy1_in : occupancy0_in};
    else if (is_grp_reg(reg_addr_in, dgr_pkg::OFS_OFFSET_DAC))
      next_rdata = {16'h0, offset_dac[{grp, dac_sel[grp][2:0]}]};
    else if (is_grp_reg(reg_addr_in, dgr_pkg::OFS_TEMP))
      next_rdata = {24'h0, grp ? temp1_in : temp0_in};
    else if (is_grp_reg(reg_addr_in, dgr_pkg::OFS_DAC_SEL))
      next_rdata = {28'h0, dac_sel[grp]};
    else if (is_grp_reg(reg_addr_in, dgr_pkg::OFS_CAL_EN))
      next_rdata = {31'h0, cal_enable_out[grp]};
    else if (is_grp_reg(reg_addr_in, dgr_pkg::OFS_CAL_DATA))
      next_rdata = {24'h0, cal_enable_out[grp] ? cal_rdata_in : 8'h00};
    else if (is_grp_reg(reg_addr_in, dgr_pkg::OFS_FT_THRESH))
      next_rdata = {16'h0, ft_threshold_out};
    else if (is_grp_reg(reg_addr_in, dgr_pkg::OFS_FT_OFFSET))
      next_rdata = {16'h0, ft_offset_out};
    else if (reg_addr_in == dgr_pkg::OFS_CFG)
      next_rdata = cfg;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      reg_rdata_out <= 32'h0000_0000;
      reg_rvalid_out <= 1'b0;
    end
    else
    begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in)
        reg_rdata_out <= next_rdata;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_accept;
    ser_start;
  endsequence

  chk_busy_rises: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    s_accept |=> busy [*8])
    else $error("busy did not hold after accepted write");

  chk_busy_drops: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    $rose(busy) |-> ##[1:50] !busy)
    else $error("busy did not release");

  chk_busy_drop_wr: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    busy && reg_wr_in && is_grp_reg(reg_addr_in, dgr_pkg::OFS_FT_OFFSET)
    |=> $stable(ft_offset_out))
    else $error("write accepted while busy");

  chk_cfg_set: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    reg_wr_in && reg_addr_in == dgr_pkg::OFS_CFG_SET |=> cfg == ($past(cfg) | $past(reg_wdata_in)))
    else $error("set alias wrong");

  chk_cfg_clear: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    reg_wr_in && reg_addr_in == dgr_pkg::OFS_CFG_CLR |=> cfg == ($past(cfg) & ~$past(reg_wdata_in)))
    else $error("clear alias wrong");

  chk_cfg_write: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    reg_wr_in && reg_addr_in == dgr_pkg::OFS_CFG |=> test_sawtooth_out == $past(reg_wdata_in[3]))
    else $error("config write wrong");

  chk_status_busy: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    reg_rd_in && is_grp_reg(reg_addr_in, dgr_pkg::OFS_STATUS) |=> reg_rdata_out[2] == $past(busy))
    else $error("status busy bit wrong");

  chk_offset_all: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    s_accept and (is_grp_reg(reg_addr_in, dgr_pkg::OFS_OFFSET_DAC) && reg_wdata_in[19:16] == 4'hf)
    |=> offset_dac[{$past(grp), 3'h7}] == $past(reg_wdata_in[15:0]))
    else $error("broadcast offset not loaded");

  chk_ft_shared: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    s_accept and is_grp_reg(reg_addr_in, dgr_pkg::OFS_FT_THRESH)
    |=> ft_threshold_out == $past(reg_wdata_in[15:0]))
    else $error("threshold not updated");

  // A frame is exactly two clocks per word bit; a short one would drop bits at the far end.
  sequence s_frame_end;
    busy ##1 !busy;
  endsequence

  chk_frame_len: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    s_accept |=> busy [*8] ##38 s_frame_end)
    else $error("serial frame length wrong");

  // Defaults are checked on the first edge out of reset, before any write can land.
  chk_offset_rst: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    $fell(sys_rst_in) |-> offset_dac[0] == dgr_pkg::OFFSET_DAC_RST
      && offset_dac[15] == dgr_pkg::OFFSET_DAC_RST)
    else $error("offset default wrong");

  chk_toff_rst: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    $fell(sys_rst_in) |-> ft_offset_out == dgr_pkg::FT_OFFSET_RST)
    else $error("trigger offset default wrong");

  chk_trig_rst: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    $fell(sys_rst_in) |-> !ft_trigger_en_out && !ft_readout_en_out)
    else $error("trigger enables not cleared by reset");

  chk_mode_rst: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    $fell(sys_rst_in) |-> !ft_falling_edge_out && !test_sawtooth_out)
    else $error("polarity or test mode not cleared by reset");

  chk_occ_width: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    reg_rd_in && is_grp_reg(reg_addr_in, dgr_pkg::OFS_OCCUPANCY) |=> reg_rdata_out[31:11] == 21'h0)
    else $error("occupancy upper bits not zero");

  chk_temp_width: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    reg_rd_in && is_grp_reg(reg_addr_in, dgr_pkg::OFS_TEMP) |=> reg_rdata_out[31:8] == 24'h0)
    else $error("temperature upper bits not zero");

  // A group zero offset write, broadcast included, must leave group one untouched.
  chk_group_split: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    s_accept and (is_grp_reg(reg_addr_in, dgr_pkg::OFS_OFFSET_DAC) && !grp)
    |=> $stable(offset_dac[8]) && $stable(offset_dac[15]))
    else $error("offset write crossed into the other group");

endmodule : dgr_bank

// ### bench/dgr_bank_test.sv
/*
  Self-checking random bench for the group register bank.
  Assumes the package and the bank are compiled first; the bench drives every port itself.
*/
`timescale 1ns/1ps
module dgr_bank_test;
  // ----------------------------------------
  // Signals and instance
  // ----------------------------------------
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [15:0] reg_addr_in = 16'h0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [31:0] reg_wdata_in = 32'h0000_0000;
  logic [31:0] fw_revision_in = 32'h0000_0000;
  logic [10:0] occupancy0_in = 11'h000;
  logic [10:0] occupancy1_in = 11'h000;
  logic [7:0] temp0_in = 8'h00;
  logic [7:0] temp1_in = 8'h00;
  logic [7:0] cal_rdata_in = 8'h00;
  logic [3:0] ext_status_in = 4'h0;
  logic [31:0] reg_rdata_out;
  logic reg_rvalid_out, ser_clk_out, ser_data_out, ser_frame_out;
  logic [1:0] cal_enable_out;
  logic [15:0] ft_threshold_out, ft_offset_out;
  logic [3:0] monitor_sel_out;
  logic ft_trigger_en_out, ft_readout_en_out, ft_falling_edge_out, test_sawtooth_out;
  logic [15:0] offset_dac_out [0:15];
  logic [15:0] exp_off [0:15];
  logic [31:0] exp_cfg, rdat;
  logic [15:0] v;
  logic [3:0] idx;
  logic [2:0] sel;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int run_len = 0;
  int last_len = 0;
  int ser_bits = 0;
  int last_bits = 0;
  logic [22:0] ser_word = 23'h000000;
  int g;
  localparam logic [31:0] ALL = 32'hffff_ffff;

  dgr_bank dgr_bank_i (.core_clk_in, .sys_rst_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
    .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .fw_revision_in, .occupancy0_in,
    .occupancy1_in, .temp0_in, .temp1_in, .cal_rdata_in, .ext_status_in, .ser_clk_out,
    .ser_data_out, .ser_frame_out, .cal_enable_out, .ft_threshold_out, .ft_offset_out,
    .monitor_sel_out, .ft_trigger_en_out, .ft_readout_en_out, .ft_falling_edge_out,
    .test_sawtooth_out, .offset_dac_out);

  // Clock at 200 MHz.
  initial
  begin
    forever #2.5 core_clk_in = ~core_clk_in;
  end

  // Measures each serial frame in clocks and cuts a hang short.
  always @(posedge core_clk_in)
  begin
    cycles <= cycles + 1;
    if (ser_frame_out === 1'b1)
      run_len <= run_len + 1;
    else if (run_len != 0)
    begin
      last_len <= run_len;
      run_len <= 0;
      last_bits <= ser_bits;
      ser_bits <= 0;
    end
    // Bits are taken while the link clock is high, one sample per bit.
    if (ser_frame_out === 1'b1 && ser_clk_out === 1'b1)
    begin
      ser_word <= {ser_word[21:0], ser_data_out};
      ser_bits <= ser_bits + 1;
    end
    if (cycles == 20000)
    begin
      errors = errors + 1;
      give_verdict();
    end
  end

  // ----------------------------------------
  // Bus tasks and expectations
  // ----------------------------------------
  task automatic give_verdict();
    if (errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
    num_checks++;
    if (got !== e)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, e, got);
    end
  endtask : chk

  function automatic logic [15:0] ga(input int grp, input logic [15:0] ofs);
    return (grp != 0) ? (ofs | dgr_pkg::GROUP_STRIDE_MASK) : ofs;
  endfunction : ga

  // Expected serial word: target, group, channel index, data, most significant bit first.
  function automatic logic [22:0] ser_exp(input logic [1:0] t, input int grp,
                                          input logic [3:0] ix, input logic [15:0] d);
    return {t, 1'(grp), ix, d};
  endfunction : ser_exp

  task automatic check_ser(input logic [22:0] e);
    chk("ser_word", {9'h000, e}, {9'h000, ser_word});
    chk("ser_bits", 32'(dgr_pkg::SER_BITS), 32'(last_bits));
  endtask : check_ser

  // An idle cycle closes every access, so a strobe is never set twice in one step.
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge core_clk_in);
    reg_wr_in = 1'b0;
    @(negedge core_clk_in);
  endtask : wr

  // Reads, then compares only the bits under the mask.
  task automatic rdm(input logic [15:0] a, input logic [31:0] e, input logic [31:0] m,
                     input string what);
    int n;
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge core_clk_in);
    reg_rd_in = 1'b0;
    n = 0;
    while (reg_rvalid_out !== 1'b1 && n < 4)
    begin
      @(negedge core_clk_in);
      n++;
    end
    chk("rvalid", 32'h1, {31'h0, reg_rvalid_out});
    rdat = reg_rdata_out;
    chk(what, e & m, rdat & m);
    @(negedge core_clk_in);
  endtask : rdm

  // The frame output follows busy, so waiting on it is the cheapest poll.
  task automatic wait_idle();
    int n;
    n = 0;
    while (ser_frame_out !== 1'b0 && n < 200)
    begin
      @(negedge core_clk_in);
      n++;
    end
    @(negedge core_clk_in);
  endtask : wait_idle

  task automatic off_wr(input int grp, input logic [3:0] ix, input logic [15:0] val);
    wr(ga(grp, dgr_pkg::OFS_OFFSET_DAC), {12'h000, ix, val});
    for (int c = 0; c < 8; c++)
      if (ix == 4'hf || ix == 4'(c)) exp_off[grp * 8 + c] = val;
  endtask : off_wr

  task automatic check_offs();
    for (int i = 0; i < 16; i++)
      chk("offset_dac", {16'h0, exp_off[i]}, {16'h0, offset_dac_out[i]});
  endtask : check_offs

  task automatic check_cfg();
    rdm(dgr_pkg::OFS_CFG, exp_cfg, ALL, "config");
    chk("monitor", {28'h0, exp_cfg[31:28]}, {28'h0, monitor_sel_out});
    chk("trig_en", {31'h0, exp_cfg[12]}, {31'h0, ft_trigger_en_out});
    chk("readout_en", {31'h0, exp_cfg[11]}, {31'h0, ft_readout_en_out});
    chk("polarity", {31'h0, exp_cfg[6]}, {31'h0, ft_falling_edge_out});
    chk("sawtooth", {31'h0, exp_cfg[3]}, {31'h0, test_sawtooth_out});
  endtask : check_cfg

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(30052));
    exp_cfg = dgr_pkg::CFG_RST;
    for (int i = 0; i < 16; i++)
      exp_off[i] = dgr_pkg::OFFSET_DAC_RST;
    repeat (6) @(negedge core_clk_in);
    sys_rst_in = 1'b0;
    @(negedge core_clk_in);
    check_offs();
    chk("ft_offset", 32'h1000, {16'h0, ft_offset_out});
    chk("ft_thresh", 32'h0, {16'h0, ft_threshold_out});
    check_cfg();
    // Pass-through read-only values, with the full occupancy boundary first.
    for (int k = 0; k < 8; k++)
    begin
      g = k % 2;
      fw_revision_in = $urandom;
      occupancy0_in = (k < 2) ? dgr_pkg::OCC_MAX : 11'($urandom_range(1024));
      occupancy1_in = (k < 2) ? dgr_pkg::OCC_MAX : 11'($urandom_range(1024));
      temp0_in = 8'($urandom_range(127));
      temp1_in = 8'($urandom_range(127));
      ext_status_in = 4'($urandom);
      rdm(ga(g, dgr_pkg::OFS_FW_REV), fw_revision_in, ALL, "fw_rev");
      rdm(ga(g, dgr_pkg::OFS_OCCUPANCY), {21'h0, g ? occupancy1_in : occupancy0_in}, ALL,
          "occupancy");
      rdm(ga(g, dgr_pkg::OFS_TEMP), {24'h0, g ? temp1_in : temp0_in}, ALL, "temp");
      rdm(ga(g, dgr_pkg::OFS_STATUS), {28'h0, ext_status_in & 4'hb}, 32'hf, "status");
      rdm(16'h10f0, 32'h0, ALL, "unmapped");
    end
    // Offset writes: a second write while busy must be lost, then readback via select.
    for (int k = 0; k < 6; k++)
    begin
      g = k % 2;
      idx = (k == 2) ? 4'hf : (k == 3) ? 4'h0 : (k == 4) ? 4'h7 : 4'($urandom_range(7));
      v = 16'($urandom);
      off_wr(g, idx, v);
      chk("frame", 32'h1, {31'h0, ser_frame_out});
      rdm(ga(g, dgr_pkg::OFS_STATUS), 32'h4, 32'h4, "busy_set");
      wr(ga(g, dgr_pkg::OFS_OFFSET_DAC), {12'h000, idx, ~v});
      wait_idle();
      chk("busy_len", 32'(2 * dgr_pkg::SER_BITS), 32'(last_len));
      check_ser(ser_exp(dgr_pkg::TGT_OFFSET, g, idx, v));
      rdm(ga(g, dgr_pkg::OFS_STATUS), 32'h0, 32'h4, "busy_clr");
      check_offs();
      sel = 3'($urandom_range(7));
      wr(ga(g, dgr_pkg::OFS_DAC_SEL), {29'h0, sel});
      rdm(ga(g, dgr_pkg::OFS_DAC_SEL), {29'h0, sel}, 32'hf, "dac_sel");
      rdm(ga(g, dgr_pkg::OFS_OFFSET_DAC), {16'h0, exp_off[g * 8 + sel]}, 32'hffff,
          "offset_read");
    end
    // Shared trigger DACs written through one group and read through the other.
    for (g = 0; g < 2; g++)
    begin
      v = 16'($urandom);
      wr(ga(g, dgr_pkg::OFS_FT_THRESH), {16'h0, v});
      wr(ga(1 - g, dgr_pkg::OFS_FT_OFFSET), {16'h0, ~v});
      wait_idle();
      check_ser(ser_exp(dgr_pkg::TGT_FT_THRESH, g, 4'h0, v));
      chk("ft_thresh", {16'h0, v}, {16'h0, ft_threshold_out});
      rdm(ga(1 - g, dgr_pkg::OFS_FT_THRESH), {16'h0, v}, 32'hffff, "thresh_rd");
      v = 16'($urandom);
      wr(ga(g, dgr_pkg::OFS_FT_OFFSET), {16'h0, v});
      wait_idle();
      check_ser(ser_exp(dgr_pkg::TGT_FT_OFFSET, g, 4'h0, v));
      chk("ft_offset", {16'h0, v}, {16'h0, ft_offset_out});
      rdm(ga(1 - g, dgr_pkg::OFS_FT_OFFSET), {16'h0, v}, 32'hffff, "toff_rd");
    end
    // Calibration access opened, used and closed per group.
    for (g = 0; g < 2; g++)
    begin
      wr(ga(g, dgr_pkg::OFS_CAL_EN), 32'h1);
      wait_idle();
      chk("cal_en", 32'(1 << g), {30'h0, cal_enable_out});
      cal_rdata_in = 8'($urandom);
      rdm(ga(g, dgr_pkg::OFS_CAL_DATA), {24'h0, cal_rdata_in}, 32'hff, "cal_rd");
      v = 16'($urandom);
      wr(ga(g, dgr_pkg::OFS_CAL_DATA), {24'h0, v[7:0]});
      chk("cal_frame", 32'h1, {31'h0, ser_frame_out});
      wait_idle();
      check_ser(ser_exp(dgr_pkg::TGT_CAL, g, 4'h0, {8'h00, v[7:0]}));
      wr(ga(g, dgr_pkg::OFS_CAL_EN), 32'h0);
      wait_idle();
      chk("cal_dis", 32'h0, {30'h0, cal_enable_out});
      rdm(ga(g, dgr_pkg::OFS_CAL_DATA), 32'h0, 32'hff, "cal_off");
    end
    // Every monitor code, with mandatory ones and zeros kept by software.
    for (int m = 0; m < 4; m++)
    begin
      exp_cfg = {4'(m), 15'h0, 2'($urandom), 2'b00, 1'b1, 1'b0, 1'($urandom), 1'b0, 1'b1,
                 1'($urandom), 3'b000};
      wr(dgr_pkg::OFS_CFG, exp_cfg);
      check_cfg();
    end
    wr(dgr_pkg::OFS_CFG_SET, 32'h1000_1848);
    exp_cfg = exp_cfg | 32'h1000_1848;
    check_cfg();
    wr(dgr_pkg::OFS_CFG_CLR, 32'h2000_1040);
    exp_cfg = exp_cfg & ~32'h2000_1040;
    check_cfg();
    give_verdict();
  end
endmodule : dgr_bank_test
